//--- rtl/strap_option_pkg.sv
// Purpose: Shared constants for the strap option latch.
// Assumes: Strap vector order given by the STRAP_* bit indices below.
// Notes: Register numbers are the management register numbers, not byte addresses.
// Operation
// (R1) Sample every strap pin once at chip reset release; hold as power-up setup.
// (R2) Three address straps form station address 0..7; default 1.
// (R3) Address 0 is broadcast unless disable strap high or 16h bit 9 set.
// (R4) Mode strap 000 selects RMII, 110 back-to-back; other codes reserved.
// (R5) Isolate strap defaults off; captured value loads 0h bit 10.
// (R6) Speed strap defaults 100 Mbps; loads 0h bit 13 and advertisement 4h.
// (R7) Duplex strap defaults high (half); loads 0h bit 8.
// (R8) Auto-negotiation strap defaults enabled; loads 0h bit 12.
// (R9) Test-tree strap is active low; low at release enables test mode.
// (R10) Strap pins are pulled inputs during reset, normal outputs afterwards.
// (R11) Outside party keeps strap pins at intended levels during reset.
// (R12) Wake strap defaults off; captured value loads the wake-control bit.
// (R13) Captured values hold until next reset; loaded bits stay software writable.
package strap_option_pkg;

    localparam int STRAP_COUNT = 13;
    localparam int DATA_WIDTH = 16;
    localparam int ADDR_WIDTH = 5;

    // Positions inside the strap vector
    localparam int STRAP_ADDR_LO = 0;
    localparam int STRAP_MODE_LO = 3;
    localparam int STRAP_WAKE = 6;
    localparam int STRAP_ISO = 7;
    localparam int STRAP_SPEED = 8;
    localparam int STRAP_DUPLEX = 9;
    localparam int STRAP_AUTONEG = 10;
    localparam int STRAP_BCAST = 11;
    localparam int STRAP_TEST_N = 12;

    // Level each pin shows when left to its weak pull
    localparam logic [STRAP_COUNT-1:0] STRAP_DEFAULT = 13'h1701;

    localparam logic [2:0] MODE_RMII = 3'h0;
    localparam logic [2:0] MODE_BACK_TO_BACK = 3'h6;

    // Register numbers
    localparam logic [ADDR_WIDTH-1:0] CTRL_ADDR = 5'h00;
    localparam logic [ADDR_WIDTH-1:0] ADVERT_ADDR = 5'h04;
    localparam logic [ADDR_WIDTH-1:0] PHY_CTRL_ADDR = 5'h16;
    localparam logic [ADDR_WIDTH-1:0] WAKE_CTRL_ADDR = 5'h1a;
    localparam logic [ADDR_WIDTH-1:0] STRAP_STATUS_ADDR = 5'h1b;

    // Control register fields
    localparam int CTRL_SPEED_BIT = 13;
    localparam int CTRL_AUTONEG_BIT = 12;
    localparam int CTRL_ISOLATE_BIT = 10;
    localparam int CTRL_DUPLEX_BIT = 8;
    localparam logic [DATA_WIDTH-1:0] CTRL_RESET = 16'h0000;

    // Advertisement: selector field plus four ability bits
    localparam logic [DATA_WIDTH-1:0] ADVERT_RESET = 16'h01e1;
    localparam logic [DATA_WIDTH-1:0] ADVERT_100_MASK = 16'h0180;

    localparam int PHY_CTRL_BCAST_OFF_BIT = 9;
    localparam logic [DATA_WIDTH-1:0] PHY_CTRL_RESET = 16'h0000;

    localparam int WAKE_EN_BIT = 0;
    localparam logic [DATA_WIDTH-1:0] WAKE_CTRL_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_CAPTURE = 2'b01,
        ST_RUN = 2'b11
    } latch_state_t;

endpackage

//--- rtl/strap_sync.sv
// Purpose: Multi-stage synchroniser for pin-level inputs.
// Assumes: Inputs are static or slow relative to sys_clk.
// Notes: Only the last stage may be read by other logic.
module strap_sync #(
    parameter int WIDTH = 1,
    parameter int STAGES = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage_reg [STAGES];

    initial begin
        if (STAGES < 2 || WIDTH < 1) begin
            $error("strap_sync needs at least two stages and one bit");
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stage_reg[0] <= RESET_VAL;
        end else begin
            stage_reg[0] <= asyncIn;
        end
    end

    genvar i;
    generate
        for (i = 1; i < STAGES; i++) begin : g_stage
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    stage_reg[i] <= RESET_VAL;
                end else begin
                    stage_reg[i] <= stage_reg[i-1];
                end
            end
        end
    endgenerate

    assign syncOut = stage_reg[STAGES-1];

endmodule

//--- rtl/strap_option_latch.sv
// Purpose: Capture configuration straps at chip reset release and seed registers.
// Assumes: chipRstN and strap pins are asynchronous to sys_clk.
// Notes: Strap levels and chip reset share one synchroniser depth, so they stay aligned.
module strap_option_latch
    import strap_option_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic chipRstN,
    input wire logic [STRAP_COUNT-1:0] strapIn,
    input wire logic [STRAP_COUNT-1:0] funcOut,
    input wire logic [STRAP_COUNT-1:0] funcOe,
    output logic [STRAP_COUNT-1:0] strapOut,
    output logic [STRAP_COUNT-1:0] strapOe,
    output logic pullEn,
    input wire logic [ADDR_WIDTH-1:0] regAddr,
    input wire logic [DATA_WIDTH-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_WIDTH-1:0] regRdata,
    output logic configValid,
    output logic [2:0] stationAddr,
    output logic addrZeroBroadcast,
    output logic backToBackMode,
    output logic modeReserved,
    output logic isolate,
    output logic speed100,
    output logic halfDuplex,
    output logic autonegEn,
    output logic testTreeEn,
    output logic wakeEn
);

    initial begin
        if (SYNC_STAGES < 2) begin
            $error("strap_option_latch needs SYNC_STAGES of two or more");
        end
        // Status register keeps its top bit for the valid flag
        if (STRAP_COUNT > DATA_WIDTH - 1) begin
            $error("strap image does not fit the status register");
        end
    end

    // Pin synchronisation

    logic [STRAP_COUNT-1:0] strapSync;
    logic [0:0] rstSyncVec;
    logic chipRunning;

    // Pins wander while the outside party settles; never sample them raw
    strap_sync #(
        .WIDTH(STRAP_COUNT),
        .STAGES(SYNC_STAGES),
        .RESET_VAL(STRAP_DEFAULT)
    ) u_strap_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .asyncIn(strapIn),
        .syncOut(strapSync)
    ); // R11

    strap_sync #(
        .WIDTH(1),
        .STAGES(SYNC_STAGES),
        .RESET_VAL(1'b0)
    ) u_rst_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .asyncIn(chipRstN),
        .syncOut(rstSyncVec)
    );

    assign chipRunning = rstSyncVec[0];

    // Sequencing

    latch_state_t state_reg;
    latch_state_t state_next;
    logic captureNow;
    logic running;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_HOLD: begin
                if (chipRunning) begin
                    state_next = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                state_next = chipRunning ? ST_RUN : ST_HOLD;
            end
            ST_RUN: begin
                if (!chipRunning) begin
                    state_next = ST_HOLD;
                end
            end
            default: begin
                state_next = ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= ST_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // Exactly one capture per reset release
    assign captureNow = (state_reg == ST_CAPTURE); // R1
    assign running = (state_reg == ST_RUN);

    // Pin direction: pulled input until captured, then normal function
    assign strapOe = running ? funcOe : '0; // R10
    assign strapOut = running ? funcOut : '0; // R10
    assign pullEn = !running; // R10

    // Captured strap image

    logic [STRAP_COUNT-1:0] latched_reg;
    logic valid_reg;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            latched_reg <= STRAP_DEFAULT;
            valid_reg <= 1'b0;
        end else begin
            // Follows the run state, so valid never outlives the pin drive
            valid_reg <= (state_next == ST_RUN);
            if (captureNow) begin
                latched_reg <= strapSync; // R1
            end
        end
    end

    // Field extraction of the captured image
    logic [2:0] capAddr;
    logic [2:0] capMode;
    logic capWake;
    logic capIso;
    logic capSpeed;
    logic capDuplex;
    logic capAutoneg;
    logic capBcastOff;
    logic capTestN;

    assign capAddr = latched_reg[STRAP_ADDR_LO +: 3]; // R2
    assign capMode = latched_reg[STRAP_MODE_LO +: 3];
    assign capWake = latched_reg[STRAP_WAKE];
    assign capIso = latched_reg[STRAP_ISO];
    assign capSpeed = latched_reg[STRAP_SPEED];
    assign capDuplex = latched_reg[STRAP_DUPLEX];
    assign capAutoneg = latched_reg[STRAP_AUTONEG];
    assign capBcastOff = latched_reg[STRAP_BCAST];
    assign capTestN = latched_reg[STRAP_TEST_N];

    // Register seeds taken straight from the synchronised pins
    logic [DATA_WIDTH-1:0] ctrlSeed;
    logic [DATA_WIDTH-1:0] advertSeed;
    logic [DATA_WIDTH-1:0] wakeSeed;

    always_comb begin
        ctrlSeed = CTRL_RESET;
        ctrlSeed[CTRL_SPEED_BIT] = strapSync[STRAP_SPEED]; // R6
        ctrlSeed[CTRL_AUTONEG_BIT] = strapSync[STRAP_AUTONEG]; // R8
        ctrlSeed[CTRL_ISOLATE_BIT] = strapSync[STRAP_ISO]; // R5
        ctrlSeed[CTRL_DUPLEX_BIT] = strapSync[STRAP_DUPLEX]; // R7
    end

    // A 10 Mbps strap withdraws both 100 Mbps abilities
    assign advertSeed = strapSync[STRAP_SPEED] ? ADVERT_RESET
        : (ADVERT_RESET & ~ADVERT_100_MASK); // R6

    always_comb begin
        wakeSeed = WAKE_CTRL_RESET;
        wakeSeed[WAKE_EN_BIT] = strapSync[STRAP_WAKE]; // R12
    end

    // Register file

    logic [DATA_WIDTH-1:0] ctrl_reg;
    logic [DATA_WIDTH-1:0] advert_reg;
    logic [DATA_WIDTH-1:0] phyCtrl_reg;
    logic [DATA_WIDTH-1:0] wakeCtrl_reg;
    logic [DATA_WIDTH-1:0] rdata_reg;

    logic wrCtrl;
    logic wrAdvert;
    logic wrPhyCtrl;
    logic wrWake;
    logic [DATA_WIDTH-1:0] strapStatus;
    logic [DATA_WIDTH-1:0] readMux;

    // Register select, shared by all write enables
    function automatic logic regHit(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic [ADDR_WIDTH-1:0] target
    );
        return addr == target;
    endfunction

    // Writes only land once the device is out of reset
    assign wrCtrl = running && regWr && regHit(regAddr, CTRL_ADDR);
    assign wrAdvert = running && regWr && regHit(regAddr, ADVERT_ADDR);
    assign wrPhyCtrl = running && regWr && regHit(regAddr, PHY_CTRL_ADDR);
    assign wrWake = running && regWr && regHit(regAddr, WAKE_CTRL_ADDR);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl_reg <= CTRL_RESET;
            advert_reg <= ADVERT_RESET;
            wakeCtrl_reg <= WAKE_CTRL_RESET;
        end else if (captureNow) begin
            ctrl_reg <= ctrlSeed; // R5
            advert_reg <= advertSeed; // R6
            wakeCtrl_reg <= wakeSeed; // R12
        end else begin
            // Software owns these bits after capture; pins are not re-read
            if (wrCtrl) begin
                ctrl_reg <= regWdata; // R13
            end
            if (wrAdvert) begin
                advert_reg <= regWdata; // R13
            end
            if (wrWake) begin
                wakeCtrl_reg <= regWdata; // R13
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || captureNow) begin
            phyCtrl_reg <= PHY_CTRL_RESET;
        end else if (wrPhyCtrl) begin
            phyCtrl_reg <= regWdata; // R3
        end
    end

    // Read-only view of what was captured
    always_comb begin
        strapStatus = '0;
        strapStatus[STRAP_COUNT-1:0] = latched_reg;
        strapStatus[DATA_WIDTH-1] = valid_reg;
    end

    always_comb begin
        readMux = '0;
        unique case (regAddr)
            CTRL_ADDR: readMux = ctrl_reg;
            ADVERT_ADDR: readMux = advert_reg;
            PHY_CTRL_ADDR: readMux = phyCtrl_reg;
            WAKE_CTRL_ADDR: readMux = wakeCtrl_reg;
            STRAP_STATUS_ADDR: readMux = strapStatus;
            default: readMux = '0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_reg <= '0;
        end else if (regRd) begin
            rdata_reg <= readMux;
        end else begin
            rdata_reg <= '0;
        end
    end

    assign regRdata = rdata_reg;

    // Configuration outputs

    // Mode decode feeds two outputs; one definition keeps them consistent
    function automatic logic modeIs(
        input logic [2:0] code,
        input logic [2:0] want
    );
        return code == want;
    endfunction

    assign configValid = valid_reg;
    assign stationAddr = capAddr; // R2
    assign addrZeroBroadcast = !(capBcastOff || phyCtrl_reg[PHY_CTRL_BCAST_OFF_BIT]); // R3
    assign backToBackMode = modeIs(capMode, MODE_BACK_TO_BACK); // R4
    // Reserved codes fall back to plain RMII and are flagged
    assign modeReserved = !modeIs(capMode, MODE_RMII)
        && !modeIs(capMode, MODE_BACK_TO_BACK); // R4
    assign isolate = ctrl_reg[CTRL_ISOLATE_BIT]; // R5
    assign speed100 = ctrl_reg[CTRL_SPEED_BIT]; // R6
    assign halfDuplex = ctrl_reg[CTRL_DUPLEX_BIT]; // R7
    assign autonegEn = ctrl_reg[CTRL_AUTONEG_BIT]; // R8
    assign testTreeEn = valid_reg && !capTestN; // R9
    assign wakeEn = wakeCtrl_reg[WAKE_EN_BIT]; // R12

endmodule

//--- dv/strap_option_latch_sva.sv
// Purpose: Port checks for the strap option latch.
// Assumes: One clock; sys_rst synchronous, active high.
// Notes: Bound to the design after the module.
module strap_option_latch_chk
    import strap_option_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic chipRstN,
    input wire logic [STRAP_COUNT-1:0] funcOe,
    input wire logic [STRAP_COUNT-1:0] strapOe,
    input wire logic pullEn,
    input wire logic [ADDR_WIDTH-1:0] regAddr,
    input wire logic [DATA_WIDTH-1:0] regWdata,
    input wire logic regWr,
    input wire logic configValid,
    input wire logic [2:0] stationAddr,
    input wire logic backToBackMode,
    input wire logic modeReserved,
    input wire logic isolate,
    input wire logic speed100,
    input wire logic halfDuplex,
    input wire logic autonegEn,
    input wire logic testTreeEn
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic [DATA_WIDTH-1:0] wdPast;
    always_ff @(posedge sys_clk) wdPast <= regWdata;
    property p_hold; !configValid |-> strapOe == '0 && pullEn; endproperty
    a_hold: assert property (p_hold) else $error("pins driven in reset");
    property p_run; configValid |-> strapOe == funcOe && !pullEn; endproperty
    a_run: assert property (p_run) else $error("pin drive wrong in run");
    property p_lost; $fell(chipRstN) |-> ##[1:5] !configValid; endproperty
    a_lost: assert property (p_lost) else $error("config kept in reset");
    property p_rise; chipRstN [*8] |-> configValid; endproperty
    a_rise: assert property (p_rise) else $error("no capture after release");
    property p_keep; configValid && $past(configValid) |-> $stable(stationAddr)
        && $stable(testTreeEn); endproperty
    a_keep: assert property (p_keep) else $error("captured value moved");
    property p_mode; backToBackMode |-> !modeReserved; endproperty
    a_mode: assert property (p_mode) else $error("mode flags clash");
    property p_test; testTreeEn |-> configValid; endproperty
    a_test: assert property (p_test) else $error("test mode before capture");
    property p_wr; regWr && configValid && regAddr == CTRL_ADDR |=>
        {speed100, autonegEn, isolate, halfDuplex} == {wdPast[CTRL_SPEED_BIT],
        wdPast[CTRL_AUTONEG_BIT], wdPast[CTRL_ISOLATE_BIT], wdPast[CTRL_DUPLEX_BIT]};
    endproperty
    a_wr: assert property (p_wr) else $error("control write lost");
endmodule

bind strap_option_latch strap_option_latch_chk #(.SYNC_STAGES(SYNC_STAGES)) i_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .chipRstN(chipRstN), .funcOe(funcOe),
    .strapOe(strapOe), .pullEn(pullEn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .configValid(configValid), .stationAddr(stationAddr),
    .backToBackMode(backToBackMode), .modeReserved(modeReserved), .isolate(isolate),
    .speed100(speed100), .halfDuplex(halfDuplex), .autonegEn(autonegEn),
    .testTreeEn(testTreeEn)
);

//--- dv/strap_board_model.sv
// Purpose: Board pulls and MAC receive inputs on the strap lines.
// Assumes: Board pulls are strong and beat the weak internal pulls.
// Notes: Undriven unpulled lines toggle so stale levels never pass.
module strap_board_model
    import strap_option_pkg::*;
(
    input wire logic sys_clk,
    input wire logic pullEn,
    input wire logic [STRAP_COUNT-1:0] strapOut,
    input wire logic [STRAP_COUNT-1:0] strapOe,
    input wire logic [STRAP_COUNT-1:0] boardVal,
    input wire logic [STRAP_COUNT-1:0] boardEn,
    output logic [STRAP_COUNT-1:0] strapIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [STRAP_COUNT-1:0] tog = '0;
    logic [STRAP_COUNT-1:0] idle;
    always_ff @(posedge sys_clk) tog <= ~tog;
    assign idle = pullEn ? STRAP_DEFAULT : tog;
    // Device drive wins, then strong board pulls, then weak pulls
    assign strapIn = (strapOe & strapOut) | (~strapOe & boardEn & boardVal)
        | (~strapOe & ~boardEn & idle);
endmodule

//--- dv/strap_option_latch_tb.sv
// Purpose: Self-checking bench for the strap option latch.
// Assumes: Board drives some straps, weak pulls set the rest.
// Notes: Every mode code is strapped once, with random other pins.
module strap_option_latch_tb
    import strap_option_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, sys_rst = 1, chipRstN = 0, regWr = 0, regRd = 0;
    logic pullEn, configValid, addrZeroBroadcast, backToBackMode, modeReserved;
    logic isolate, speed100, halfDuplex, autonegEn, testTreeEn, wakeEn;
    logic [2:0] stationAddr;
    logic [STRAP_COUNT-1:0] strapIn, strapOut, strapOe, funcOut = '0, funcOe = '0;
    logic [STRAP_COUNT-1:0] boardVal = '0, boardEn = '0, s, e, img;
    logic [ADDR_WIDTH-1:0] regAddr = '0;
    logic [DATA_WIDTH-1:0] regWdata = '0, regRdata, d;
    int badCount = 0, samplesChecked = 0;
    strap_option_latch i_strap_option_latch (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .chipRstN(chipRstN), .strapIn(strapIn),
        .funcOut(funcOut), .funcOe(funcOe), .strapOut(strapOut), .strapOe(strapOe),
        .pullEn(pullEn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .configValid(configValid),
        .stationAddr(stationAddr), .addrZeroBroadcast(addrZeroBroadcast),
        .backToBackMode(backToBackMode), .modeReserved(modeReserved), .isolate(isolate),
        .speed100(speed100), .halfDuplex(halfDuplex), .autonegEn(autonegEn),
        .testTreeEn(testTreeEn), .wakeEn(wakeEn)
    );
    strap_board_model i_strap_board_model (
        .sys_clk(sys_clk), .pullEn(pullEn), .strapOut(strapOut), .strapOe(strapOe),
        .boardVal(boardVal), .boardEn(boardEn), .strapIn(strapIn)
    );
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [DATA_WIDTH-1:0] seen, input logic [DATA_WIDTH-1:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            badCount++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic endOfTest;
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] v);
        @(posedge sys_clk);
        regWr <= 1;
        regAddr <= a;
        regWdata <= v;
        @(posedge sys_clk);
        regWr <= 0;
        @(negedge sys_clk);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] exp);
        @(posedge sys_clk);
        regRd <= 1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 0;
        @(negedge sys_clk);
        check(regRdata, exp);
    endtask
    function automatic logic [DATA_WIDTH-1:0] ctrlExp(input logic [STRAP_COUNT-1:0] i);
        logic [DATA_WIDTH-1:0] r;
        r = CTRL_RESET;
        r[CTRL_SPEED_BIT] = i[STRAP_SPEED];
        r[CTRL_AUTONEG_BIT] = i[STRAP_AUTONEG];
        r[CTRL_ISOLATE_BIT] = i[STRAP_ISO];
        r[CTRL_DUPLEX_BIT] = i[STRAP_DUPLEX];
        return r;
    endfunction
    task automatic boot(input logic [STRAP_COUNT-1:0] v, input logic [STRAP_COUNT-1:0] en);
        int n;
        @(posedge sys_clk);
        chipRstN <= 0;
        boardVal <= v;
        boardEn <= en;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        check(strapOe, '0);
        check(pullEn, 1'b1);
        @(posedge sys_clk);
        chipRstN <= 1;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (configValid !== 1'b1 && n < 20);
        if (n >= 20) badCount++;
        // MAC turns its receive pins round once the capture is done
        @(posedge sys_clk);
        boardVal <= ~v;
    endtask
    task automatic verify(input logic [STRAP_COUNT-1:0] i);
        repeat (3) @(negedge sys_clk);
        check(stationAddr, i[2:0]);
        check(backToBackMode, i[5:3] == MODE_BACK_TO_BACK);
        check(modeReserved, i[5:3] != MODE_RMII && i[5:3] != MODE_BACK_TO_BACK);
        check(isolate, i[STRAP_ISO]);
        check(speed100, i[STRAP_SPEED]);
        check(halfDuplex, i[STRAP_DUPLEX]);
        check(autonegEn, i[STRAP_AUTONEG]);
        check(addrZeroBroadcast, !i[STRAP_BCAST]);
        check(testTreeEn, !i[STRAP_TEST_N]);
        check(wakeEn, i[STRAP_WAKE]);
        check(strapOe, funcOe);
        check(strapOut, funcOut);
        rd(CTRL_ADDR, ctrlExp(i));
        rd(ADVERT_ADDR, i[STRAP_SPEED] ? ADVERT_RESET : ADVERT_RESET & ~ADVERT_100_MASK);
        rd(STRAP_STATUS_ADDR, {1'b1, 2'b00, i});
        rd(PHY_CTRL_ADDR, PHY_CTRL_RESET);
        rd(WAKE_CTRL_ADDR, 16'(i[STRAP_WAKE]) << WAKE_EN_BIT);
    endtask
    initial begin
        void'($urandom(32'h279f));
        repeat (4) @(posedge sys_clk);
        sys_rst <= 0;
        funcOut <= 13'($urandom);
        funcOe <= 13'($urandom);
        boot('0, '0);
        verify(STRAP_DEFAULT);
        d = 16'($urandom);
        wr(CTRL_ADDR, d);
        check({speed100, autonegEn, isolate, halfDuplex}, {d[13], d[12], d[10], d[8]});
        wr(PHY_CTRL_ADDR, 16'h0001 << PHY_CTRL_BCAST_OFF_BIT);
        check(addrZeroBroadcast, 1'b0);
        rd(PHY_CTRL_ADDR, 16'h0001 << PHY_CTRL_BCAST_OFF_BIT);
        wr(WAKE_CTRL_ADDR, 16'h0001 << WAKE_EN_BIT);
        check(wakeEn, 1'b1);
        rd(WAKE_CTRL_ADDR, 16'h0001 << WAKE_EN_BIT);
        rd(5'h1f, 16'h0000);
        for (int m = 0; m < 8; m++) begin
            s = 13'($urandom);
            e = 13'($urandom) | 13'h0038;
            s[5:3] = 3'(m);
            img = (s & e) | (STRAP_DEFAULT & ~e);
            boot(s, e);
            verify(img);
        end
        endOfTest;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        badCount++;
        endOfTest;
    end
endmodule
